/* File: design/cbc_seq.sv */
/*
 * cbc_seq: machine-cycle sequencer of an 8-bit processor. Drives the
 * address and data buses and the bus strobes, inserts waits, refresh,
 * bus hold, halt, interrupts and the reset sequence. Instruction
 * execution is reduced to fetch: the next cycle request comes from
 * the core through req_*; with no request it keeps fetching.
 * Assumes reset_i is the inverted, already synchronised reset pin;
 * pins named _n_i are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
// Operation
// - drive 16-bit address for memory and I/O, 8-bit two-way data
// - bus hold taken at machine cycle end, ahead of nmi
// - grant floats address, data and strobes on the edge it asserts grant
// - sample hold request at last state; float on next edge
// - halt asserts stopped flag, fetches no-ops until an interrupt
// - maskable request honoured at instruction end only if enabled
// - io_access_n only while low address holds an I/O port, or in acknowledge
// - fetch with memory marks opcode fetch, with I/O acknowledge
// - nmi falling edge, outranks irq, ignores enable, goes to 0066H
// - nmi runs fetch-like cycle, discards data, restarts at 0066H
// - reset clears enable latch, pc, vector, refresh, sets mode 0
// - during reset buses float and controls are inactive
// - after reset three states pass, then fetch from 0000
// - refresh strobe with memory strobe in T3 and T4 of fetch
// - wait sampled in T2; waits inserted while it is active
// - fetch puts pc out, then memory and read strobes together in T2
// - memory write asserts memory strobe, store strobe with stable data
// - each I/O cycle gets one automatic wait state
// - acknowledge uses io strobe, two waits; peripheral gives vector
module cbc_seq
    import cbc_pkg::*;
#(
    parameter int ADDR_W = CBC_ADDR_W,
    parameter int DATA_W = CBC_DATA_W
)(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              wait_n_i,
    input  wire logic              irq_n_i,
    input  wire logic              nmi_n_i,
    input  wire logic              bus_hold_request_n_i,
    input  wire logic              req_valid_i,
    input  wire logic [2:0]        req_op_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic              req_last_i,
    input  wire logic [DATA_W-1:0] data_i,
    output logic [ADDR_W-1:0]      addr_o,
    output logic                   addr_oe_o,
    output logic [DATA_W-1:0]      data_o,
    output logic                   data_oe_o,
    output logic                   mem_access_n_o,
    output logic                   io_access_n_o,
    output logic                   read_strobe_n_o,
    output logic                   store_strobe_n_o,
    output logic                   ctrl_oe_o,
    output logic                   fetch_cycle_n_o,
    output logic                   refresh_strobe_n_o,
    output logic                   stopped_flag_n_o,
    output logic                   bus_hold_grant_n_o,
    output logic                   cycle_done_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   irq_enable_latch_o,
    output logic [1:0]             irq_mode_o,
    output logic [ADDR_W-1:0]      pc_o
);
    if (ADDR_W != 16 || DATA_W != 8) begin : g_width_check
        $error("cbc_seq serves only a 16-bit address, 8-bit data");
    end

    // ************************************************************
    // synchronisers
    // ************************************************************
    logic [2:0] s1;
    logic [2:0] s2;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1 <= 3'h7;
            s2 <= 3'h7;
        end else begin
            s1 <= {wait_n_i, irq_n_i, bus_hold_request_n_i};
            s2 <= s1;
        end
    end
    wire wait_act = ~s2[2];
    wire irq_act  = ~s2[1];
    wire hold_act = ~s2[0];

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [3:0] {
        ST_BOOT, ST_T1, ST_T2, ST_TW, ST_T3, ST_T4, ST_HOLD
    } cbc_st_t;

    cbc_st_t             st;
    cbc_op_t             op;
    logic [1:0]          cnt;
    logic                nmi_take;
    logic                nmi_pend;
    logic [ADDR_W-1:0]   pc;
    logic [ADDR_W-1:0]   cyc_addr;
    logic [DATA_W-1:0]   wdata;
    logic [CBC_REFRESH_STROBE_N_W:0] refresh_strobe_n;
    logic [DATA_W-1:0]   vec_reg;
    logic                halted;
    logic                instr_end;

    cbc_nmi_edge u_nmi (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .nmi_n_i   (nmi_n_i),
        .take_i    (nmi_take),
        .pending_o (nmi_pend)
    );

    function automatic logic is_io(input cbc_op_t o);
        return o == CBC_OP_IO_RD || o == CBC_OP_IO_WR;
    endfunction
    function automatic logic is_fetch(input cbc_op_t o);
        return o == CBC_OP_FETCH || o == CBC_OP_NMI_FETCH;
    endfunction

    // ************************************************************
    // cycle choice at the last state
    // ************************************************************
    wire last_state = (st == ST_T4) ||
                      (st == ST_T3 && !is_fetch(op) && op != CBC_OP_INT_ACK);
    // a pending core request keeps the instruction open unless halted
    wire end_of_instr = last_state &&
                        (halted || (instr_end && !req_valid_i));
    wire go_nmi  = end_of_instr && nmi_pend;
    wire go_irq  = end_of_instr && !nmi_pend && irq_act &&
                   irq_enable_latch_o;
    wire use_req = req_valid_i && !end_of_instr;
    wire [1:0] auto_waits = is_io(op) ? CBC_IO_WAITS :
                            (op == CBC_OP_INT_ACK) ? CBC_ACK_WAITS : 2'h0;
    wire opcode_halt = (op == CBC_OP_FETCH) && (data_i == CBC_HALT_CODE);
    // under hold the nmi stays pending and is taken after the hold
    wire cbc_op_t next_op = nmi_take ? CBC_OP_NMI_FETCH :
                            go_irq  ? CBC_OP_INT_ACK :
                            use_req ? cbc_op_t'(req_op_i) :
                            CBC_OP_FETCH;
    wire next_fetch_pc = is_fetch(next_op) && !nmi_take;

    assign nmi_take = go_nmi && !hold_act;
    assign pc_o     = pc;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st                 <= ST_BOOT;
            cnt                <= 2'h0;
            op                 <= CBC_OP_FETCH;
            pc                 <= CBC_RESET_PC;
            refresh_strobe_n               <= '0;
            vec_reg            <= '0;
            irq_enable_latch_o <= 1'b0;
            irq_mode_o         <= CBC_IM_RESET;
            cyc_addr           <= '0;
            wdata              <= '0;
            rdata_o            <= '0;
            cycle_done_o       <= 1'b0;
            halted             <= 1'b0;
            instr_end          <= 1'b1;
        end else begin
            cycle_done_o <= 1'b0;
            case (st)
                ST_BOOT: begin
                    cnt <= cnt + 2'h1;
                    if (cnt == CBC_RESUME_T - 2'h1) begin
                        st       <= ST_T1;
                        cyc_addr <= pc;
                    end
                end
                ST_T1: begin
                    st  <= ST_T2;
                    cnt <= auto_waits[1:0];
                end
                ST_T2, ST_TW: begin
                    // automatic waits first, then the external wait
                    if (cnt != 2'h0) begin
                        st  <= ST_TW;
                        cnt <= cnt - 2'h1;
                    end else if (wait_act) begin
                        st <= ST_TW;
                    end else begin
                        st <= ST_T3;
                    end
                end
                ST_T3: begin
                    // strobe pins lag state, so data stands on this edge
                    rdata_o <= data_i;
                    if (op == CBC_OP_INT_ACK)
                        vec_reg <= data_i;
                    if (op == CBC_OP_FETCH) begin
                        pc <= pc + 16'h1;
                        instr_end <= 1'b1;
                        if (opcode_halt)
                            halted <= 1'b1;
                        if (data_i == CBC_EI_CODE)
                            irq_enable_latch_o <= 1'b1;
                        if (data_i == CBC_DI_CODE)
                            irq_enable_latch_o <= 1'b0;
                    end
                    if (halted && op == CBC_OP_FETCH)
                        pc <= pc;
                    if (is_fetch(op) || op == CBC_OP_INT_ACK)
                        st <= ST_T4;
                    else
                        st <= ST_T1;
                end
                ST_HOLD: begin
                    if (!hold_act)
                        st <= ST_T1;
                end
                default: st <= ST_BOOT;
            endcase
            if (st == ST_T4)
                refresh_strobe_n[CBC_REFRESH_STROBE_N_W-1:0] <= refresh_strobe_n[CBC_REFRESH_STROBE_N_W-1:0] + 7'h1;
            if (last_state) begin
                cycle_done_o <= 1'b1;
                if (nmi_take || go_irq) begin
                    halted             <= 1'b0;
                    irq_enable_latch_o <= 1'b0;
                end
                if (nmi_take)
                    pc <= CBC_NMI_VECTOR;
                op       <= next_op;
                wdata    <= req_wdata_i;
                instr_end <= use_req ? req_last_i : 1'b0;
                cyc_addr <= next_fetch_pc ? pc : req_addr_i;
                // hold outranks nmi: cycle is parked, nmi stays pending
                st <= hold_act ? ST_HOLD : ST_T1;
                if (nmi_take)
                    cyc_addr <= pc;
            end
        end
    end

    // ************************************************************
    // pin drive, all from flip-flops
    // ************************************************************
    wire on_bus  = st == ST_T1 || st == ST_T2 || st == ST_TW ||
                   st == ST_T3 || st == ST_T4;
    wire in_refr = is_fetch(op) && (st == ST_T3 || st == ST_T4);
    wire is_wr   = op == CBC_OP_MEM_WR || op == CBC_OP_IO_WR;
    wire is_mem  = op != CBC_OP_INT_ACK && !is_io(op);
    wire next_addr_oe;
    wire next_mem_n;
    wire next_io_n;
    wire next_rd_n;
    wire next_wr_n;
    wire next_m1_n;
    wire [ADDR_W-1:0] next_addr;
    // outputs lag state by a register stage so every pin is a flop
    assign next_addr_oe = on_bus;
    assign next_addr = in_refr ? {8'h00, 1'b0, refresh_strobe_n[CBC_REFRESH_STROBE_N_W-1:0]}
                               : cyc_addr;
    assign next_mem_n = !(on_bus && is_mem &&
                        (st != ST_T1 || is_wr));
    assign next_io_n  = !((st == ST_T2 || st == ST_TW) &&
                        (is_io(op) || op == CBC_OP_INT_ACK));
    assign next_rd_n  = !(is_mem && !is_wr && !in_refr &&
                        (st == ST_T2 || st == ST_TW)) &&
                        !(op == CBC_OP_IO_RD && (st == ST_T2 || st == ST_TW));
    assign next_wr_n  = !(is_wr && (st == ST_T2 || st == ST_TW));
    assign next_m1_n  = !((is_fetch(op) || op == CBC_OP_INT_ACK) &&
                        (st == ST_T1 || st == ST_T2 || st == ST_TW));

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            addr_o             <= '0;
            addr_oe_o          <= 1'b0;
            data_o             <= '0;
            data_oe_o          <= 1'b0;
            ctrl_oe_o          <= 1'b0;
            mem_access_n_o     <= 1'b1;
            io_access_n_o      <= 1'b1;
            read_strobe_n_o    <= 1'b1;
            store_strobe_n_o   <= 1'b1;
            fetch_cycle_n_o    <= 1'b1;
            refresh_strobe_n_o <= 1'b1;
            stopped_flag_n_o   <= 1'b1;
            bus_hold_grant_n_o <= 1'b1;
        end else begin
            addr_o             <= next_addr;
            addr_oe_o          <= next_addr_oe;
            ctrl_oe_o          <= next_addr_oe;
            data_o             <= wdata;
            data_oe_o          <= on_bus && is_wr && st != ST_T1;
            mem_access_n_o     <= next_mem_n;
            io_access_n_o      <= next_io_n;
            read_strobe_n_o    <= next_rd_n;
            store_strobe_n_o   <= next_wr_n;
            fetch_cycle_n_o    <= next_m1_n;
            refresh_strobe_n_o <= !in_refr;
            stopped_flag_n_o   <= !halted;
            bus_hold_grant_n_o <= !(st == ST_HOLD);
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_grant_float;
        @(posedge clk_i) disable iff (reset_i)
        !bus_hold_grant_n_o |-> !addr_oe_o && !data_oe_o && !ctrl_oe_o;
    endproperty
    a_grant_float: assert property (p_grant_float)
        else $error("bus driven while granted");

    property p_hold_grant;
        @(posedge clk_i) disable iff (reset_i)
        last_state && hold_act |=> ##1 !bus_hold_grant_n_o;
    endproperty
    a_hold_grant: assert property (p_hold_grant)
        else $error("hold not granted after last state");

    property p_hold_over_nmi;
        @(posedge clk_i) disable iff (reset_i)
        go_nmi && hold_act |=> st == ST_HOLD && nmi_pend;
    endproperty
    a_hold_over_nmi: assert property (p_hold_over_nmi)
        else $error("nmi taken ahead of bus hold");

    property p_fetch_refresh;
        @(posedge clk_i) disable iff (reset_i)
        !refresh_strobe_n_o |-> !mem_access_n_o && fetch_cycle_n_o;
    endproperty
    a_fetch_refresh: assert property (p_fetch_refresh)
        else $error("refresh without memory strobe");

    property p_io_strobe;
        @(posedge clk_i) disable iff (reset_i)
        !io_access_n_o |-> mem_access_n_o && addr_oe_o;
    endproperty
    a_io_strobe: assert property (p_io_strobe)
        else $error("io strobe with memory strobe");

    property p_nmi_vector;
        @(posedge clk_i) disable iff (reset_i)
        go_nmi && !hold_act |=> pc == CBC_NMI_VECTOR;
    endproperty
    a_nmi_vector: assert property (p_nmi_vector)
        else $error("nmi did not restart at vector");

    property p_irq_gate;
        @(posedge clk_i) disable iff (reset_i)
        go_irq |-> irq_enable_latch_o && !nmi_pend;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq taken while disabled");

    property p_boot;
        @(posedge clk_i) $fell(reset_i) |-> st == ST_BOOT ##3 st == ST_T1
            && cyc_addr == CBC_RESET_PC;
    endproperty
    a_boot: assert property (p_boot)
        else $error("first fetch not after three states");

    property p_io_wait;
        @(posedge clk_i) disable iff (reset_i)
        st == ST_T1 && is_io(op) |=> ##1 st == ST_TW;
    endproperty
    a_io_wait: assert property (p_io_wait)
        else $error("io cycle without automatic wait");
endmodule

/* File: design/cbc_pkg.sv */
/*
 * cbc_pkg: constants for the bus-cycle and control sequencer.
 * Assumes a single 10 MHz processor clock; no software registers.
 */
package cbc_pkg;
    localparam int          CBC_ADDR_W     = 16;
    localparam int          CBC_DATA_W     = 8;
    localparam int          CBC_REFRESH_STROBE_N_W     = 7;
    localparam logic [15:0] CBC_RESET_PC   = 16'h0000;
    localparam logic [15:0] CBC_NMI_VECTOR = 16'h0066;
    localparam logic [1:0]  CBC_IM_RESET   = 2'h0;
    localparam logic [7:0]  CBC_NOP_CODE   = 8'h00;
    localparam logic [7:0]  CBC_HALT_CODE  = 8'h76;
    localparam logic [7:0]  CBC_EI_CODE    = 8'hFB;
    localparam logic [7:0]  CBC_DI_CODE    = 8'hF3;
    localparam logic [1:0]  CBC_RESUME_T   = 2'h3;
    localparam logic [1:0]  CBC_IO_WAITS   = 2'h1;
    localparam logic [1:0]  CBC_ACK_WAITS  = 2'h2;
    localparam int          CBC_RST_MIN_CYC = 3;

    typedef enum logic [2:0] {
        CBC_OP_FETCH,
        CBC_OP_MEM_RD,
        CBC_OP_MEM_WR,
        CBC_OP_IO_RD,
        CBC_OP_IO_WR,
        CBC_OP_INT_ACK,
        CBC_OP_NMI_FETCH
    } cbc_op_t;
endpackage

/* File: design/cbc_nmi_edge.sv */
/*
 * cbc_nmi_edge: synchronises the non-maskable request pin and latches
 * a pending flag on each falling edge until the sequencer takes it.
 * Assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/1ns
module cbc_nmi_edge
    import cbc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic nmi_n_i,
    input  wire logic take_i,
    output logic      pending_o
);
    logic sync1;
    logic sync2;
    logic prev;
    wire  fall_seen = prev & ~sync2;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1     <= 1'b1;
            sync2     <= 1'b1;
            prev      <= 1'b1;
            pending_o <= 1'b0;
        end else begin
            sync1     <= nmi_n_i;
            sync2     <= sync1;
            prev      <= sync2;
            // new edge beats the take in the same cycle
            pending_o <= fall_seen | (pending_o & ~take_i);
        end
    end

    property p_nmi_latch;
        @(posedge clk_i) disable iff (reset_i)
        fall_seen |=> pending_o;
    endproperty
    a_nmi_latch: assert property (p_nmi_latch)
        else $error("nmi edge not latched");
endmodule

/* File: verif/cbc_bus_model.sv */
/* cbc_bus_model: memory, I/O port and interrupting peripheral on the
   far side of cbc_seq. Assumes strobes are valid only with ctrl_oe_i. */
`timescale 1ns/1ns
module cbc_bus_model
    import cbc_pkg::*;
#(
    parameter logic [7:0] ACK_VECTOR = 8'h00
)(
    input  wire logic        clk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        mem_access_n_i,
    input  wire logic        io_access_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic        store_strobe_n_i,
    input  wire logic        fetch_cycle_n_i,
    input  wire logic        ctrl_oe_i,
    input  wire logic        data_oe_i,
    input  wire logic [7:0]  data_i,
    output logic [7:0]       data_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last;
    logic [7:0] value;
    wire rd_sel  = ctrl_oe_i & !read_strobe_n_i
                 & (!mem_access_n_i | !io_access_n_i);
    wire ack_sel = ctrl_oe_i & !io_access_n_i & !fetch_cycle_n_i;
    wire wr_sel  = ctrl_oe_i & data_oe_i & !store_strobe_n_i
                 & !mem_access_n_i;

    initial begin
        last = 8'h00;
        foreach (mem[i]) mem[i] = CBC_NOP_CODE;
    end
    // vector on acknowledge, port value on I/O read
    assign value  = ack_sel ? ACK_VECTOR :
                    (!io_access_n_i ? addr_i[7:0] ^ 8'hA5 : mem[addr_i]);
    // released bus shows the inverse of the last byte, never a hold
    assign data_o = (rd_sel | ack_sel) ? value : ~last;

    always @(posedge clk_i) begin
        if (rd_sel | ack_sel) begin
            last <= value;
        end
        if (wr_sel) begin
            mem[addr_i] <= data_i;
        end
    end
endmodule

/* File: verif/test_cpu_bus_cycle_control.sv */
/* test_cpu_bus_cycle_control: self-checking bench for cbc_seq.
   Assumes cbc_bus_model answers reads; core requests come from here. */
`timescale 1ns/1ns
module test_cpu_bus_cycle_control import cbc_pkg::*;;
    logic        clk_i, reset_i, wait_n_i, irq_n_i, nmi_n_i;
    logic        bus_hold_request_n_i, req_valid_i, req_last_i;
    logic [2:0]  req_op_i;
    logic [15:0] req_addr_i, addr_o, pc_o;
    logic [7:0]  req_wdata_i, data_i, data_o, rdata_o, model_data;
    logic        addr_oe_o, data_oe_o, mem_access_n_o, io_access_n_o;
    logic        read_strobe_n_o, store_strobe_n_o, ctrl_oe_o;
    logic        fetch_cycle_n_o, refresh_strobe_n_o, stopped_flag_n_o;
    logic        bus_hold_grant_n_o, cycle_done_o, irq_enable_latch_o;
    logic [1:0]  irq_mode_o;
    int          num_errors, total_checks, n;

    assign data_i = data_oe_o ? data_o : model_data;

    cbc_seq cbc_seq_i (.clk_i, .reset_i, .wait_n_i, .irq_n_i, .nmi_n_i,
        .bus_hold_request_n_i, .req_valid_i, .req_op_i, .req_addr_i,
        .req_wdata_i, .req_last_i, .data_i, .addr_o, .addr_oe_o, .data_o,
        .data_oe_o, .mem_access_n_o, .io_access_n_o, .read_strobe_n_o,
        .store_strobe_n_o, .ctrl_oe_o, .fetch_cycle_n_o,
        .refresh_strobe_n_o, .stopped_flag_n_o, .bus_hold_grant_n_o,
        .cycle_done_o, .rdata_o, .irq_enable_latch_o, .irq_mode_o, .pc_o);

    cbc_bus_model cbc_bus_model_i (.clk_i, .addr_i(addr_o),
        .mem_access_n_i(mem_access_n_o), .io_access_n_i(io_access_n_o),
        .read_strobe_n_i(read_strobe_n_o),
        .store_strobe_n_i(store_strobe_n_o),
        .fetch_cycle_n_i(fetch_cycle_n_o), .ctrl_oe_i(ctrl_oe_o),
        .data_oe_i(data_oe_o), .data_i(data_o), .data_o(model_data));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    function automatic logic cond(input int sel);
        case (sel)
            0: return fetch_cycle_n_o === 1'b0 && mem_access_n_o === 1'b0;
            1: return stopped_flag_n_o === 1'b0;
            2: return fetch_cycle_n_o === 1'b0 && io_access_n_o === 1'b0;
            3: return store_strobe_n_o === 1'b0;
            4: return io_access_n_o === 1'b0;
            5: return bus_hold_grant_n_o === 1'b0;
            6: return bus_hold_grant_n_o === 1'b1 && addr_oe_o === 1'b1;
            7: return cycle_done_o === 1'b1;
            8: return refresh_strobe_n_o === 1'b0;
            9: return cond(0) && addr_o === CBC_NMI_VECTOR;
            default: return 1'b0;
        endcase
    endfunction

    // a wait that runs out is a mismatch and ends the run
    task automatic wait_on(input int sel, input int bound);
        for (int i = 0; i < bound; i++) begin
            @(negedge clk_i);
            if (cond(sel)) return;
        end
        check(16'h0000, 16'h0001);
        results();
    endtask

    task automatic request(input logic [2:0] op, input logic [15:0] a,
                           input logic [7:0] d);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_op_i    <= op;
        req_addr_i  <= a;
        req_wdata_i <= d;
        wait_on(7, 20);
        wait_on(7, 20);
    endtask

    // states between two cycle ends
    task automatic measure(output int cnt);
        wait_on(7, 40);
        cnt = 0;
        do begin
            @(negedge clk_i);
            cnt++;
        end while (cycle_done_o !== 1'b1 && cnt < 40);
    endtask

    task automatic pulse_nmi();
        @(posedge clk_i);
        nmi_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nmi_n_i <= 1'b1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic boot();
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        check({addr_oe_o, data_oe_o, ctrl_oe_o}, 3'h0);
        check({mem_access_n_o, io_access_n_o, read_strobe_n_o,
               store_strobe_n_o, bus_hold_grant_n_o}, 5'h1F);
        check({pc_o, irq_enable_latch_o}, 17'h0);
        check(irq_mode_o, CBC_IM_RESET);
        @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) begin
            @(negedge clk_i);
            check(fetch_cycle_n_o, 1'b1);
        end
        wait_on(0, 6);
        check({addr_o, read_strobe_n_o}, {CBC_RESET_PC, 1'b0});
        wait_on(8, 6);
        check({mem_access_n_o, read_strobe_n_o}, 2'h1);
        check(addr_o[6:0], 7'h00);
        wait_on(7, 8);
        wait_on(8, 8);
        check(addr_o[6:0], 7'h01);
    endtask

    task automatic halt_and_irq();
        wait_on(1, 20);
        @(posedge clk_i);
        irq_n_i <= 1'b0;
        repeat (30) @(negedge clk_i);
        check(stopped_flag_n_o, 1'b0);
        wait_on(8, 10);
        check(mem_access_n_o, 1'b0);
        @(posedge clk_i);
        irq_n_i <= 1'b1;
        pulse_nmi();
        wait_on(9, 60);
        check(stopped_flag_n_o, 1'b1);
        wait_on(1, 40);
        check(irq_enable_latch_o, 1'b1);
        @(posedge clk_i);
        irq_n_i <= 1'b0;
        wait_on(2, 40);
        check(mem_access_n_o, 1'b1);
        @(posedge clk_i);
        irq_n_i <= 1'b1;
        wait_on(0, 20);
        check(stopped_flag_n_o, 1'b1);
    endtask

    task automatic bus_cycles();
        int cnt;
        request(CBC_OP_MEM_WR, 16'h1234, 8'h5A);
        wait_on(3, 20);
        check(addr_o, 16'h1234);
        check({data_o, data_oe_o, mem_access_n_o}, 10'h16A);
        request(CBC_OP_MEM_RD, 16'h1234, 8'h00);
        measure(n);
        check(n[15:0], 16'h0003);
        check(rdata_o, 8'h5A);
        request(CBC_OP_IO_RD, 16'h3C77, 8'h00);
        wait_on(4, 20);
        check({mem_access_n_o, addr_o[7:0]}, 9'h177);
        measure(n);
        check(n[15:0], 16'h0004);
        check(rdata_o, 8'h77 ^ 8'hA5);
        request(CBC_OP_IO_WR, 16'h0055, 8'h99);
        wait_on(3, 20);
        check({io_access_n_o, addr_o[7:0], data_o}, 17'h05599);
        request(CBC_OP_MEM_RD, 16'h1234, 8'h00);
        @(posedge clk_i);
        wait_n_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        cnt = 0;
        repeat (12) begin
            @(negedge clk_i);
            if (cycle_done_o === 1'b1) cnt++;
        end
        check({cnt <= 1, read_strobe_n_o}, 2'h2);
        @(posedge clk_i);
        wait_n_i <= 1'b1;
        wait_on(7, 10);
    endtask

    task automatic bus_hold();
        @(posedge clk_i);
        req_valid_i          <= 1'b0;
        bus_hold_request_n_i <= 1'b0;
        wait_on(5, 20);
        check({addr_oe_o, data_oe_o, ctrl_oe_o}, 3'h0);
        pulse_nmi();
        repeat (10) begin
            @(negedge clk_i);
            check({bus_hold_grant_n_o, ctrl_oe_o, addr_oe_o}, 3'h0);
        end
        @(posedge clk_i);
        bus_hold_request_n_i <= 1'b1;
        wait_on(6, 20);
        wait_on(9, 40);
        check(addr_o, CBC_NMI_VECTOR);
    endtask

    initial begin
        num_errors           = 0;
        total_checks         = 0;
        reset_i              = 1'b1;
        wait_n_i             = 1'b1;
        irq_n_i              = 1'b1;
        nmi_n_i              = 1'b1;
        bus_hold_request_n_i = 1'b1;
        req_valid_i          = 1'b0;
        req_op_i             = CBC_OP_FETCH;
        req_addr_i           = 16'h0000;
        req_wdata_i          = 8'h00;
        req_last_i           = 1'b1;
        #1;
        cbc_bus_model_i.mem[16'h0000] = CBC_HALT_CODE;
        cbc_bus_model_i.mem[16'h0066] = CBC_EI_CODE;
        cbc_bus_model_i.mem[16'h0067] = CBC_HALT_CODE;
        boot();
        halt_and_irq();
        bus_cycles();
        bus_hold();
        results();
    end
endmodule
